// *** design/readout_pkg.sv ***
// Constants and carriers shared by the hit scan and the chain readout.
// Assumes one rising-edge clock and a synchronous active-low clear.
package readout_pkg;
	localparam int CHANNELS = 128;
	localparam int IDX_W = 7;
	localparam int PAT_W = 3;
	localparam int SAMPLES = 3;
	localparam int TRIG_W = 4;
	localparam int BUNCH_W = 8;
	localparam int CONF_W = 16;
	localparam int RIDX_W = 5;
	localparam logic [6:0] LAST_CHANNEL = 7'h7f;
	localparam logic [1:0] CRIT_ANY = 2'h0;
	localparam logic [1:0] CRIT_LEVEL = 2'h1;
	localparam logic [1:0] CRIT_EDGE = 2'h2;
	localparam int ADDR_W = 4;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h4;
	localparam int MODE_W = 5;
	localparam logic [4:0] MODE_RESET = 5'h00;
	localparam int PKT_W = 32;
	localparam int LEN_W = 6;
	localparam logic [2:0] MARK_HDR = 3'h5;
	localparam logic [1:0] MARK_START = 2'h2;
	localparam logic [1:0] MARK_CONT = 2'h3;
	localparam logic [3:0] CODE_END = 4'h4;
	localparam logic [7:0] CODE_NOHIT = 8'h0e;
	localparam logic [3:0] MARK_ERR = 4'he;
	localparam logic [3:0] MARK_ID = 4'hd;
	localparam logic [3:0] MARK_REG = 4'hc;
	localparam logic [2:0] ERR_OVF = 3'h1;
	localparam logic [2:0] ERR_BUF = 3'h2;
	localparam logic [2:0] ERR_NODATA = 3'h3;
	localparam logic [5:0] LEN_HDR = 6'h0a;
	localparam logic [5:0] LEN_HDR_MASTER = 6'h16;
	localparam logic [5:0] LEN_START = 6'h0c;
	localparam logic [5:0] LEN_CONT = 6'h05;
	localparam logic [5:0] LEN_END = 6'h04;
	localparam logic [5:0] LEN_NOHIT = 6'h08;
	localparam logic [5:0] LEN_ERR = 6'h07;
	localparam logic [5:0] LEN_ID = 6'h1b;
	localparam logic [5:0] LEN_REG = 6'h19;
	localparam logic [5:0] TOKEN_LEAD = 6'h03;

	typedef struct packed {
		logic [1:0] crit;
		logic ident;
		logic dump;
		logic master;
	} mode_s;

	typedef struct packed {
		logic valid;
		logic done;
		logic lost;
		logic adj;
		logic busy;
		logic [6:0] idx;
		logic [2:0] pat;
	} hit_s;
endpackage

// *** design/hit_scan.sv ***
// Hit scan: fetches one event, transposes it, presents matching channels.
// Assumes buffer words appear on sample_word the cycle after each strobe.
`timescale 1ns/1ns
`default_nettype none
module hit_scan (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [readout_pkg::CHANNELS-1:0] sample_word,
	input wire logic buf_nonempty,
	input wire logic overflow,
	input wire readout_pkg::mode_s mode,
	input wire logic advance_request,
	output logic buffer_read_strobe,
	output readout_pkg::hit_s hit
);
	import readout_pkg::*;

	typedef enum logic [5:0] {
		SC_IDLE = 6'h01,
		SC_FETCH = 6'h02,
		SC_EVAL = 6'h04,
		SC_PRESENT = 6'h08,
		SC_DONE = 6'h10,
		SC_LOST = 6'h20
	} scan_e;

	scan_e state;
	logic [1:0] issued;
	logic [1:0] taken;
	logic word_due;
	logic [CHANNELS-1:0] word [SAMPLES];
	logic [IDX_W-1:0] idx;
	logic [PAT_W-1:0] pat;
	logic [PAT_W-1:0] pattern [CHANNELS];
	logic [CHANNELS-1:0] match;
	logic [CHANNELS-1:0] after;
	logic [IDX_W-1:0] next_idx;

	// Lowest set bit wins, which keeps the scan in channel order
	function automatic logic [IDX_W-1:0] first_set(input logic [CHANNELS-1:0] vec);
		logic [IDX_W-1:0] pos;
		pos = '0;
		for (int c = CHANNELS - 1; c >= 0; c--) begin
			if (vec[c]) begin
				pos = IDX_W'(c);
			end
		end
		return pos;
	endfunction

	for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
		assign pattern[c] = {word[0][c], word[1][c], word[2][c]};
		assign match[c] = (mode.crit == CRIT_ANY) ? |pattern[c] :
			(mode.crit == CRIT_LEVEL) ? pattern[c][1] :
			(mode.crit == CRIT_EDGE) ? (pattern[c][2:1] == 2'h1) : 1'b1;
		assign after[c] = match[c] && (IDX_W'(c) > idx);
	end

	assign next_idx = first_set((state == SC_EVAL) ? match : after);
	assign buffer_read_strobe = (state == SC_FETCH) && (issued != 2'(SAMPLES));
	assign hit.valid = (state == SC_PRESENT);
	assign hit.done = (state == SC_DONE) || (hit.valid && !(|after));
	assign hit.lost = (state == SC_LOST);
	assign hit.adj = hit.valid && (idx != LAST_CHANNEL) && match[idx + 7'h01];
	assign hit.busy = (state != SC_IDLE);
	assign hit.idx = idx;
	assign hit.pat = pat;

	// Sample storage needs no reset; it is only read after a full fetch
	always_ff @(posedge clk) begin
		if (word_due) begin
			word[taken] <= sample_word;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state <= SC_IDLE;
			issued <= '0;
			taken <= '0;
			word_due <= 1'b0;
			idx <= '0;
			pat <= '0;
		end else begin
			word_due <= buffer_read_strobe;
			unique case (state)
				SC_IDLE: begin
					issued <= '0;
					taken <= '0;
					if (buf_nonempty) state <= SC_FETCH;
				end
				SC_FETCH: begin
					if (buffer_read_strobe) issued <= issued + 2'h1;
					if (word_due) taken <= taken + 2'h1;
					if (word_due && taken == 2'(SAMPLES - 1)) state <= SC_EVAL;
				end
				SC_EVAL: begin
					idx <= next_idx;
					pat <= pattern[next_idx];
					// Identify and dump outrank overflow, so those events close as done
					if (mode.ident || mode.dump) state <= SC_DONE;
					else if (overflow) state <= SC_LOST;
					else if (!(|match)) state <= SC_DONE;
					else state <= SC_PRESENT;
				end
				SC_PRESENT: begin
					if (advance_request && |after) begin
						idx <= next_idx;
						pat <= pattern[next_idx];
					end else if (advance_request) begin
						state <= SC_DONE;
					end
				end
				SC_DONE, SC_LOST: if (advance_request) state <= SC_IDLE;
				default: state <= SC_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_fetch_three: assert property (
		state == SC_IDLE && buf_nonempty |=>
		buffer_read_strobe [*3] ##1 !buffer_read_strobe)
		else $error("event fetch did not strobe three words");
	a_hold_hit: assert property (
		hit.valid && !advance_request |=> hit.valid && $stable(hit.idx) && $stable(hit.pat))
		else $error("presented hit changed without advance");
	a_adj_next: assert property (
		hit.adj && advance_request |=> hit.valid && hit.idx == $past(hit.idx) + 7'h01)
		else $error("adjacent flag not followed by next channel");
	a_edge_crit: assert property (
		hit.valid && mode.crit == CRIT_EDGE |-> hit.pat[2:1] == 2'h1)
		else $error("edge criterion presented a non-edge pattern");
	a_lost_status: assert property (
		state == SC_EVAL && overflow && !mode.ident && !mode.dump |=>
		hit.lost && !hit.valid && !hit.done)
		else $error("overflowed event not reported as lost");
	a_skip_priority: assert property (
		state == SC_EVAL && (mode.ident || mode.dump) |=> hit.done && !hit.lost && !hit.valid)
		else $error("identify or dump event not skipped ahead of overflow");
endmodule // hit_scan
`default_nettype wire

// *** design/hit_chain_readout.sv ***
// Hit chain readout: token sequencer and serialiser over the hit scan.
// Assumes the readout buffer, counters and config registers sit outside.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module hit_chain_readout (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic [readout_pkg::ADDR_W-1:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WSTROBE,
	input wire logic RSTROBE,
	output logic [31:0] RDATA,
	input wire logic [readout_pkg::CHANNELS-1:0] SAMPLE_WORD,
	input wire logic BUF_NONEMPTY,
	input wire logic BUF_OVERFLOW,
	input wire logic BUF_ERROR,
	output logic BUFFER_READ_STROBE,
	input wire logic CHAIN_PASS_IN,
	output logic CHAIN_PASS_OUT,
	output logic SERIAL_OUT,
	output logic SERIAL_VALID,
	input wire logic [readout_pkg::IDX_W-1:0] CHIP_ADDRESS,
	input wire logic [readout_pkg::CONF_W-1:0] CONFIG_WORD,
	input wire logic [readout_pkg::CONF_W-1:0] READBACK_DATA,
	input wire logic [readout_pkg::RIDX_W-1:0] READBACK_INDEX,
	input wire logic [readout_pkg::TRIG_W-1:0] TRIG_COUNT,
	input wire logic [readout_pkg::BUNCH_W-1:0] BUNCH_COUNT
);
	import readout_pkg::*;

	typedef enum logic [3:0] {
		RD_IDLE = 4'h1,
		RD_WAIT = 4'h2,
		RD_SHIFT = 4'h4,
		RD_HIT = 4'h8
	} seq_e;

	seq_e seq;
	mode_s mode;
	hit_s hit;
	logic ovf_seen;
	logic advance_request;
	logic [PKT_W-1:0] shifter;
	logic [LEN_W-1:0] remain;
	logic final_pkt;
	logic prev_adj;
	logic pass_out;
	logic flush;
	logic [31:0] rdata;

	logic wr_ctrl;
	logic [31:0] stat_word;
	logic [31:0] rd_sel;
	logic event_ready;
	logic no_data;
	logic decide;
	logic send_hits;
	logic load;
	logic [2:0] err_code;
	logic [PKT_W-1:0] id_pkt;
	logic [PKT_W-1:0] reg_pkt;
	logic [PKT_W-1:0] err_pkt;
	logic [PKT_W-1:0] hdr_pkt;
	logic [PKT_W-1:0] nohit_pkt;
	logic [PKT_W-1:0] start_pkt;
	logic [PKT_W-1:0] cont_pkt;
	logic [PKT_W-1:0] end_pkt;
	logic [PKT_W-1:0] open_pkt;
	logic [LEN_W-1:0] open_len;
	logic [PKT_W-1:0] hit_pkt;
	logic [LEN_W-1:0] hit_len;
	logic [LEN_W-1:0] hdr_len;
	logic [PKT_W-1:0] next_pkt;
	logic [LEN_W-1:0] next_len;
	logic next_final;

	hit_scan u_scan (
		.clk(CLK),
		.rst_b(RST_B),
		.sample_word(SAMPLE_WORD),
		.buf_nonempty(BUF_NONEMPTY),
		.overflow(ovf_seen),
		.mode(mode),
		.advance_request(advance_request),
		.buffer_read_strobe(BUFFER_READ_STROBE),
		.hit(hit)
	);

	// Register port: control word steers the scan and packet choice
	assign wr_ctrl = WSTROBE && (ADDR == ADDR_CTRL);
	assign stat_word = {24'h000000, seq, ovf_seen, hit.valid, hit.done, hit.lost};
	assign rd_sel = (ADDR == ADDR_CTRL) ? {27'h0000000, mode} :
		(ADDR == ADDR_STAT) ? stat_word :
		32'h00000000;
	assign RDATA = rdata;

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			mode <= mode_s'(MODE_RESET);
		end else if (wr_ctrl) begin
			mode <= mode_s'(WDATA[MODE_W-1:0]);
		end
	end

	// Read data stand for the one cycle after the strobe, zero otherwise
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			rdata <= 32'h00000000;
		end else begin
			rdata <= RSTROBE ? rd_sel : 32'h00000000;
		end
	end

	// Sticky so that later events are flushed too, not only the one hit
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			ovf_seen <= 1'b0;
		end else begin
			ovf_seen <= ovf_seen || BUF_OVERFLOW;
		end
	end

	// Event and error conditions seen while holding the token
	assign event_ready = hit.valid || hit.done || hit.lost;
	assign no_data = !hit.busy && !BUF_NONEMPTY;
	assign decide = (seq == RD_WAIT) && (event_ready || no_data || BUF_ERROR);
	assign send_hits = !mode.ident && !mode.dump && !hit.lost && !BUF_ERROR &&
		!no_data && hit.valid;

	// Packets are left aligned; the top bit leaves first
	assign id_pkt = {MARK_ID, CHIP_ADDRESS, CONFIG_WORD, 5'h00};
	assign reg_pkt = {MARK_REG, READBACK_INDEX, READBACK_DATA, 7'h00};
	assign err_code = hit.lost ? ERR_OVF :
		BUF_ERROR ? ERR_BUF :
		ERR_NODATA;
	assign err_pkt = {MARK_ERR, err_code, 25'h0000000};
	assign hdr_pkt = mode.master ?
		{MARK_HDR, TRIG_COUNT, BUNCH_COUNT, CHIP_ADDRESS, 10'h000} :
		{MARK_HDR, CHIP_ADDRESS, 22'h000000};
	assign hdr_len = mode.master ? LEN_HDR_MASTER : LEN_HDR;
	assign nohit_pkt = {CODE_NOHIT, 24'h000000};
	assign start_pkt = {MARK_START, hit.idx, hit.pat, 20'h00000};
	assign cont_pkt = {MARK_CONT, hit.pat, 27'h0000000};
	assign end_pkt = {CODE_END, 28'h0000000};

	// Identify outranks everything, so no hit or error leaves in that mode
	assign open_pkt = mode.ident ? id_pkt :
		mode.dump ? reg_pkt :
		(hit.lost || BUF_ERROR || no_data) ? err_pkt :
		hit.valid ? hdr_pkt :
		nohit_pkt;
	assign open_len = mode.ident ? LEN_ID :
		mode.dump ? LEN_REG :
		(hit.lost || BUF_ERROR || no_data) ? LEN_ERR :
		hit.valid ? hdr_len :
		LEN_NOHIT;

	// Only the first channel of a run carries its address
	assign hit_pkt = !hit.valid ? end_pkt :
		prev_adj ? cont_pkt :
		start_pkt;
	assign hit_len = !hit.valid ? LEN_END :
		prev_adj ? LEN_CONT :
		LEN_START;

	assign load = decide || (seq == RD_HIT);
	assign next_pkt = (seq == RD_HIT) ? hit_pkt : open_pkt;
	assign next_len = (seq == RD_HIT) ? hit_len : open_len;
	assign next_final = (seq == RD_HIT) ? !hit.valid : !send_hits;

	// Each hit and the event close consume one step of the scan
	assign advance_request = (decide && !send_hits && event_ready) ||
		(seq == RD_HIT) || flush;

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			seq <= RD_IDLE;
		end else begin
			unique case (seq)
				RD_IDLE: begin
					if (CHAIN_PASS_IN) seq <= RD_WAIT;
				end
				RD_WAIT: begin
					if (decide) seq <= RD_SHIFT;
				end
				RD_HIT: begin
					seq <= RD_SHIFT;
				end
				RD_SHIFT: begin
					if (remain == 6'h01) begin
						seq <= final_pkt ? RD_IDLE : RD_HIT;
					end
				end
				default: seq <= RD_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			shifter <= '0;
			remain <= '0;
			final_pkt <= 1'b0;
		end else if (load) begin
			shifter <= next_pkt;
			remain <= next_len;
			final_pkt <= next_final;
		end else if (seq == RD_SHIFT) begin
			shifter <= shifter << 1;
			remain <= remain - 6'h01;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			prev_adj <= 1'b0;
		end else if (seq == RD_HIT) begin
			prev_adj <= hit.adj;
		end else if (decide) begin
			prev_adj <= 1'b0;
		end
	end

	// Hits left behind an error packet are stepped off, else the next event would inherit them
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			flush <= 1'b0;
		end else begin
			flush <= (decide && !send_hits && hit.valid) || (flush && hit.valid);
		end
	end

	// Token leads the last bit by one cycle, per the chain timing
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			pass_out <= 1'b0;
		end else begin
			pass_out <= (seq == RD_SHIFT) && final_pkt && (remain == TOKEN_LEAD);
		end
	end

	assign CHAIN_PASS_OUT = pass_out;
	assign SERIAL_OUT = shifter[PKT_W-1];
	assign SERIAL_VALID = (seq == RD_SHIFT);

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	a_token_early: assert property (
		CHAIN_PASS_OUT |->
		SERIAL_VALID ##1 (SERIAL_VALID && !CHAIN_PASS_OUT) ##1 !SERIAL_VALID)
		else $error("token not passed one bit before packet end");

	a_overflow_sticky: assert property (
		ovf_seen |=> ovf_seen)
		else $error("overflow indication dropped without reset");

	a_idle_token: assert property (
		seq == RD_IDLE && !CHAIN_PASS_IN |=> seq == RD_IDLE && !SERIAL_VALID)
		else $error("readout left idle without a token");

	a_special_advance: assert property (
		decide && mode.ident && hit.done |-> advance_request ##1 !advance_request)
		else $error("identify packet did not consume the event");

	a_clear_idle: assert property (
		disable iff (1'b0)
		!RST_B |=> seq == RD_IDLE && !CHAIN_PASS_OUT && !advance_request && !hit.valid)
		else $error("clear did not return readout to idle");
endmodule // hit_chain_readout
`default_nettype wire

// *** sim/chain_neighbour.sv ***
// Chain neighbours: the upstream chip that hands in the token, the downstream one that takes it.
// Assumes one clock shared with the chip; tokens are one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
module chain_neighbour (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic token_back,
	output logic token_fwd
);
	int got;
	initial token_fwd = 1'b0;
	// Caller offers a token only while the chip sits idle, since busy chips ignore it
	task automatic send();
		@(posedge clk);
		token_fwd <= 1'b1;
		@(posedge clk);
		token_fwd <= 1'b0;
	endtask
	always @(posedge clk) begin
		if (!rst_b) got <= 0;
		else if (token_back) got <= got + 1;
	end
endmodule // chain_neighbour
`default_nettype wire

// *** sim/hit_chain_readout_tb.sv ***
// Bench for the hit chain readout: buffer model, token neighbour and a bit-level stream model.
// Assumes buffer words appear the cycle after each read strobe.
`timescale 1ns/1ns
`default_nettype none
module hit_chain_readout_tb;
	import readout_pkg::*;
	logic CLK = 0, RST_B = 0, WSTROBE = 0, RSTROBE = 0;
	logic BUF_NONEMPTY = 0, BUF_OVERFLOW = 0, BUF_ERROR = 0;
	logic [3:0] ADDR = 4'h0, TRIG_COUNT = 4'h0;
	logic [31:0] WDATA = 32'h0, RDATA, rd_val;
	logic [127:0] SAMPLE_WORD = 128'h0;
	logic [6:0] CHIP_ADDRESS = 7'h0;
	logic [15:0] CONFIG_WORD = 16'h0, READBACK_DATA = 16'h0;
	logic [4:0] READBACK_INDEX = 5'h0, ctrl = 5'h0;
	logic [7:0] BUNCH_COUNT = 8'h0;
	logic BUFFER_READ_STROBE, CHAIN_PASS_IN, CHAIN_PASS_OUT, SERIAL_OUT, SERIAL_VALID;
	logic [127:0] bufq[$];
	logic [127:0] w[3];
	logic got_q[$], exp_q[$];
	int n_mismatch = 0, comparisons = 0, cyc = 0, tok_cyc, last_cyc, strobes, seed = 92;
	bit ovf = 0;

	hit_chain_readout dut_u (.CLK, .RST_B, .ADDR, .WDATA, .WSTROBE, .RSTROBE, .RDATA,
		.SAMPLE_WORD, .BUF_NONEMPTY, .BUF_OVERFLOW, .BUF_ERROR, .BUFFER_READ_STROBE,
		.CHAIN_PASS_IN, .CHAIN_PASS_OUT, .SERIAL_OUT, .SERIAL_VALID, .CHIP_ADDRESS,
		.CONFIG_WORD, .READBACK_DATA, .READBACK_INDEX, .TRIG_COUNT, .BUNCH_COUNT);
	chain_neighbour nb_u (.clk(CLK), .rst_b(RST_B), .token_back(CHAIN_PASS_OUT),
		.token_fwd(CHAIN_PASS_IN));

	always #5 CLK = ~CLK;
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (SERIAL_VALID) begin
			got_q.push_back(SERIAL_OUT);
			last_cyc = cyc;
		end
		if (CHAIN_PASS_OUT) tok_cyc = cyc;
		// A pop past the end shows garbage, never a stale word
		if (BUFFER_READ_STROBE) begin
			strobes++;
			SAMPLE_WORD <= bufq.size() ? bufq.pop_front() : ~SAMPLE_WORD;
		end
		BUF_NONEMPTY <= bufq.size() >= 3;
		if (cyc > 60000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WSTROBE <= 1'b1;
		if (a == ADDR_CTRL) ctrl = d[4:0];
		@(posedge CLK);
		WSTROBE <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge CLK);
		ADDR <= a;
		RSTROBE <= 1'b1;
		@(posedge CLK);
		RSTROBE <= 1'b0;
		#1 rd_val = RDATA;
	endtask
	task automatic put(input logic [31:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) exp_q.push_back(v[i]);
	endtask
	function automatic logic match(input logic [2:0] p);
		case (ctrl[4:3])
			2'h0: return |p;
			2'h1: return p[1];
			2'h2: return !p[2] && p[1];
			default: return 1'b1;
		endcase
	endfunction
	task automatic model(input bit have);
		int prev;
		logic [2:0] p;
		bit any;
		prev = -2;
		any = 0;
		exp_q.delete();
		if (ctrl[2]) put({MARK_ID, CHIP_ADDRESS, CONFIG_WORD}, 27);
		else if (ctrl[1]) put({MARK_REG, READBACK_INDEX, READBACK_DATA}, 25);
		else if (ovf) put({MARK_ERR, ERR_OVF}, 7);
		else if (BUF_ERROR) put({MARK_ERR, ERR_BUF}, 7);
		else if (!have) put({MARK_ERR, ERR_NODATA}, 7);
		else begin
			for (int c = 0; c < CHANNELS; c++) begin
				p = {w[0][c], w[1][c], w[2][c]};
				if (!match(p)) continue;
				if (!any && ctrl[0]) put({MARK_HDR, TRIG_COUNT, BUNCH_COUNT, CHIP_ADDRESS}, 22);
				else if (!any) put({MARK_HDR, CHIP_ADDRESS}, 10);
				if (c == prev + 1) put({MARK_CONT, p}, 5);
				else put({MARK_START, c[6:0], p}, 12);
				any = 1;
				prev = c;
			end
			if (any) put(CODE_END, 4);
			else put(CODE_NOHIT, 8);
		end
	endtask
	task automatic run_event(input bit have, input string what);
		int n;
		int g;
		got_q.delete();
		strobes = 0;
		tok_cyc = 0;
		g = nb_u.got;
		if (have) for (int i = 0; i < 3; i++) bufq.push_back(w[i]);
		model(have);
		repeat (12) @(posedge CLK);
		nb_u.send();
		n = 0;
		while (nb_u.got == g && n < 3000) begin
			@(posedge CLK);
			n++;
		end
		if (n >= 3000) n_mismatch++;
		repeat (4) @(posedge CLK);
		chk({what, " length"}, got_q.size(), exp_q.size());
		foreach (exp_q[i]) if (got_q.size() > i) chk({what, " bit"}, got_q[i], exp_q[i]);
		chk({what, " token"}, tok_cyc + 1, last_cyc);
		chk({what, " strobes"}, strobes, have ? 3 : 0);
		rd(ADDR_STAT);
		chk({what, " status"}, rd_val[7:0], {4'h1, ovf, 3'h0});
		$display("Test %s done", what);
	endtask
	task automatic wrap_up();
		$display("Checks %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge CLK);
		RST_B <= 1'b1;
		{CHIP_ADDRESS, CONFIG_WORD, READBACK_DATA, READBACK_INDEX, TRIG_COUNT, BUNCH_COUNT} <=
			56'({$random(seed), $random(seed)});
		rd(ADDR_STAT);
		chk("status reset", rd_val, 32'h10);
		wr(ADDR_CTRL, 32'hffffffff);
		rd(ADDR_CTRL);
		chk("control", rd_val, 32'h1f);
		wr(ADDR_STAT, 32'hffffffff);
		rd(ADDR_STAT);
		chk("status write", rd_val, 32'h10);
		rd(4'h8);
		chk("unmapped", rd_val, 32'h0);
		wr(ADDR_CTRL, 32'h0);
		$display("Test registers done");
		run_event(0, "no data");
		// Every criterion, slave then master, with a neighbour run and the last channel hit
		for (int k = 0; k < 8; k++) begin
			wr(ADDR_CTRL, {27'h0, k[1:0], 2'h0, k[2]});
			for (int i = 0; i < 3; i++) begin
				for (int j = 0; j < 4; j++) w[i][j*32+:32] = $random(seed) & $random(seed) & $random(seed);
				w[i][127] = (i == 1);
				w[i][7:5] = {3{i == 1}};
			end
			run_event(1, "criteria");
		end
		wr(ADDR_CTRL, 32'h0);
		w = '{default: 128'h0};
		run_event(1, "no hit");
		wr(ADDR_CTRL, 32'h6);
		run_event(1, "identify");
		wr(ADDR_CTRL, 32'h2);
		run_event(1, "dump");
		wr(ADDR_CTRL, 32'h0);
		// Two hits pending behind the error packet must still be consumed
		w[1] = 128'h5;
		BUF_ERROR <= 1'b1;
		@(posedge CLK);
		run_event(1, "buffer error");
		BUF_ERROR <= 1'b0;
		BUF_OVERFLOW <= 1'b1;
		@(posedge CLK);
		BUF_OVERFLOW <= 1'b0;
		ovf = 1;
		run_event(1, "overflow");
		run_event(1, "overflow kept");
		RST_B <= 1'b0;
		repeat (2) @(posedge CLK);
		RST_B <= 1'b1;
		ovf = 0;
		ctrl = 5'h0;
		rd(ADDR_STAT);
		chk("status cleared", rd_val, 32'h10);
		$display("Test reset done");
		wrap_up();
	end
endmodule // hit_chain_readout_tb
`default_nettype wire
